// ### hw/irq_priority_mask_trigger.sv
// one eight-level bank: priority, rotation, masking, ack sequencing
`timescale 1ns/1ps
`include "irq_defines.svh"
module irq_priority_mask_trigger import irq_pkg::*; #(
  parameter int         N           = 8,
  parameter int         LW          = `VEC_LEVEL_BITS,
  parameter logic [7:0] VECTOR_BASE = `VEC_BASE_DEFAULT
) (
  input  logic         clk,
  input  logic         nrst,
  input  logic [N-1:0] req_n,
  input  logic         ack_strobe,
  input  logic         cmd_valid,
  input  cmd_op_t      cmd_op,
  input  logic [LW-1:0] cmd_level,
  input  logic         mask_wr,
  input  logic [N-1:0] mask_wdata,
  output logic         cpu_request_out,
  output logic [7:0]   data_out,
  output logic         data_oe,
  output logic [N-1:0] level_mask_out,
  output logic [N-1:0] pending_out,
  output logic [N-1:0] in_service_out,
  output logic [LW-1:0] lowest_out
);

  // mode and mask state
  logic         auto_end_of_service_reg;
  logic         auto_end_of_service_next;
  logic         rot_auto_end_of_service_reg;
  logic         rot_auto_end_of_service_next;
  logic         smm_reg;
  logic         smm_next;
  logic         level_mode_reg;
  logic         level_mode_next;
  logic [N-1:0] mask_reg;
  logic [N-1:0] mask_next;

  // priority state
  logic [N-1:0]  isr_reg;
  logic [N-1:0]  isr_next;
  logic [LW-1:0] lowest_reg;
  logic [LW-1:0] lowest_next;
  logic [N-1:0]  isr_clr;

  // acknowledge sequencing
  ack_state_t    ack_state_reg;
  ack_state_t    ack_state_next;
  logic [LW-1:0] svc_level_reg;
  logic [LW-1:0] svc_level_next;
  logic          svc_valid_reg;
  logic          svc_valid_next;
  logic [7:0]    data_reg;
  logic [7:0]    data_next;
  logic          oe_reg;
  logic          oe_next;
  logic [N-1:0]  isr_set;
  logic [N-1:0]  irr_clr;
  logic          auto_eoi_fire;

  // resolution
  logic [N-1:0]  pending_request_reg;
  logic [N-1:0]  unmasked;
  logic [N-1:0]  cand_bits;
  logic          cand_found;
  logic [LW-1:0] cand_level;
  logic [LW-1:0] cand_rank;
  logic          isr_found;
  logic [LW-1:0] isr_top;
  logic [LW-1:0] isr_rank;
  logic          allowed;
  logic          svc_ok;

  irq_trigger_detect #(
    .N(N)
  ) u_trigger (
    .clk        (clk),
    .nrst       (nrst),
    .req_n      (req_n),
    .level_mode (level_mode_reg),
    .clr_bits   (irr_clr),
    .pending    (pending_request_reg)
  );

  irq_priority_resolve #(
    .N  (N),
    .LW (LW)
  ) u_cand (
    .bits   (cand_bits),
    .lowest (lowest_reg),
    .found  (cand_found),
    .level  (cand_level),
    .rank   (cand_rank)
  );

  irq_priority_resolve #(
    .N  (N),
    .LW (LW)
  ) u_isr (
    .bits   (isr_reg),
    .lowest (lowest_reg),
    .found  (isr_found),
    .level  (isr_top),
    .rank   (isr_rank)
  );

  // request gating, combinational on current state and the raw req_n lines
  always_comb begin
    unmasked  = pending_request_reg & ~mask_reg;
    cand_bits = smm_reg ? (unmasked & ~isr_reg) : unmasked;
    // rank 0 is highest; the top in-service level blocks its own rank and below
    allowed   = cand_found & (smm_reg | ~isr_found | (cand_rank < isr_rank));
    // a request that went away before the first ack is not serviced
    svc_ok    = allowed & ~req_n[cand_level];
  end

  // mode group
  always_comb begin
    auto_end_of_service_next       = auto_end_of_service_reg;
    rot_auto_end_of_service_next   = rot_auto_end_of_service_reg;
    smm_next        = smm_reg;
    level_mode_next = level_mode_reg;
    mask_next       = mask_wr ? mask_wdata : mask_reg;
    if (cmd_valid) begin
      case (cmd_op)
        CMD_AUTO_END_OF_SERVICE_SET:     auto_end_of_service_next = 1'b1;
        CMD_AUTO_END_OF_SERVICE_CLR:     auto_end_of_service_next = 1'b0;
        CMD_ROT_AUTO_END_OF_SERVICE_SET: rot_auto_end_of_service_next = 1'b1;
        CMD_ROT_AUTO_END_OF_SERVICE_CLR: rot_auto_end_of_service_next = 1'b0;
        CMD_SMM_SET:      smm_next = 1'b1;
        CMD_SMM_CLR:      smm_next = 1'b0;
        CMD_EDGE_MODE:    level_mode_next = 1'b0;
        CMD_LEVEL_MODE:   level_mode_next = 1'b1;
        default:          ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      auto_end_of_service_reg       <= 1'b0;
      rot_auto_end_of_service_reg   <= 1'b0;
      smm_reg        <= 1'b0;
      level_mode_reg <= 1'b0;
      mask_reg       <= `MASK_RESET;
    end else begin
      auto_end_of_service_reg       <= auto_end_of_service_next;
      rot_auto_end_of_service_reg   <= rot_auto_end_of_service_next;
      smm_reg        <= smm_next;
      level_mode_reg <= level_mode_next;
      mask_reg       <= mask_next;
    end
  end

  // acknowledge group: first ack resolves, second ack presents the vector
  always_comb begin
    ack_state_next = ack_state_reg;
    svc_level_next = svc_level_reg;
    svc_valid_next = svc_valid_reg;
    data_next      = data_reg;
    oe_next        = 1'b0;
    isr_set        = '0;
    irr_clr        = '0;
    auto_eoi_fire  = 1'b0;
    case (ack_state_reg)
      ACK_IDLE: begin
        if (ack_strobe) begin
          ack_state_next = ACK_WAIT;
          data_next      = `ACK1_DATA;
          oe_next        = 1'b1;
          if (svc_ok) begin
            svc_level_next      = cand_level;
            svc_valid_next      = 1'b1;
            isr_set[cand_level] = 1'b1;
            irr_clr[cand_level] = 1'b1;
          end else begin
            svc_level_next = `DEFAULT_LEVEL;
            svc_valid_next = 1'b0;
          end
        end
      end
      ACK_WAIT: begin
        if (ack_strobe) begin
          ack_state_next = ACK_IDLE;
          data_next      = {VECTOR_BASE[7:LW], svc_level_reg};
          oe_next        = 1'b1;
          auto_eoi_fire  = svc_valid_reg & (auto_end_of_service_reg | rot_auto_end_of_service_reg);
        end
      end
      default: ack_state_next = ACK_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_state_reg <= ACK_IDLE;
      svc_level_reg <= `DEFAULT_LEVEL;
      svc_valid_reg <= 1'b0;
      data_reg      <= `ACK1_DATA;
      oe_reg        <= 1'b0;
    end else begin
      ack_state_reg <= ack_state_next;
      svc_level_reg <= svc_level_next;
      svc_valid_reg <= svc_valid_next;
      data_reg      <= data_next;
      oe_reg        <= oe_next;
    end
  end

  // priority group: in-service bits and rotation point
  always_comb begin
    isr_clr     = '0;
    lowest_next = lowest_reg;
    if (cmd_valid) begin
      case (cmd_op)
        CMD_EOI_NONSPEC: begin
          if (isr_found) begin
            isr_clr[isr_top] = 1'b1;
          end
        end
        CMD_ROT_NONSPEC: begin
          if (isr_found) begin
            isr_clr[isr_top] = 1'b1;
            lowest_next      = isr_top;
          end
        end
        CMD_EOI_SPEC: isr_clr[cmd_level] = 1'b1;
        CMD_ROT_SPEC: begin
          isr_clr[cmd_level] = 1'b1;
          lowest_next        = cmd_level;
        end
        CMD_SET_PRIO: lowest_next = cmd_level;
        default:      ;
      endcase
    end
    // auto clear acts like a nonspecific clear at the end of the second ack
    if (auto_eoi_fire && isr_found) begin
      isr_clr[isr_top] = 1'b1;
      if (rot_auto_end_of_service_reg) begin
        lowest_next = isr_top;
      end
    end
    // a new in-service bit wins over a clear of the same bit
    isr_next = (isr_reg & ~isr_clr) | isr_set;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      isr_reg    <= '0;
      lowest_reg <= `LOWEST_RESET;
    end else begin
      isr_reg    <= isr_next;
      lowest_reg <= lowest_next;
    end
  end

  assign cpu_request_out = allowed;
  assign data_out        = data_reg;
  assign data_oe         = oe_reg;
  assign level_mask_out  = mask_reg;
  assign pending_out     = pending_request_reg;
  assign in_service_out  = isr_reg;
  assign lowest_out      = lowest_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  reset_order_a: assert property (
    $rose(nrst) |-> (lowest_reg == `LOWEST_RESET && isr_reg == '0 && !smm_reg && !rot_auto_end_of_service_reg))
    else $error("state after reset is not the default order");

  isr_set_a: assert property (
    (ack_state_reg == ACK_IDLE && ack_strobe && svc_ok) |=> isr_reg[$past(cand_level)])
    else $error("acknowledged level not marked in service");

  vector_out_a: assert property (
    (ack_state_reg == ACK_WAIT && ack_strobe) |=>
      (data_oe && data_out[LW-1:0] == $past(svc_level_reg)) ##1 !data_oe)
    else $error("second ack vector wrong or held too long");

  isr_hold_a: assert property (
    (!cmd_valid && !(ack_strobe && ack_state_reg == ACK_WAIT)) |=>
      ((isr_reg & $past(isr_reg)) == $past(isr_reg)))
    else $error("in-service bit dropped without a clear");

  block_lower_a: assert property (
    (!smm_reg && isr_found && (cand_rank >= isr_rank)) |-> !cpu_request_out)
    else $error("equal or lower priority request not blocked");

  rot_nonspec_a: assert property (
    (cmd_valid && cmd_op == CMD_ROT_NONSPEC && isr_found && !ack_strobe) |=>
      (lowest_reg == $past(isr_top) && !isr_reg[$past(isr_top)]))
    else $error("rotate on nonspecific clear did not rotate");

  set_prio_a: assert property (
    (cmd_valid && cmd_op == CMD_SET_PRIO && !ack_strobe) |=>
      (lowest_reg == $past(cmd_level) && isr_reg == $past(isr_reg)))
    else $error("set priority wrong or touched in-service");

  spec_eoi_a: assert property (
    (cmd_valid && cmd_op == CMD_EOI_SPEC && !ack_strobe) |=>
      (!isr_reg[$past(cmd_level)] && lowest_reg == $past(lowest_reg)))
    else $error("specific clear missed its bit or rotated");

  mask_gate_a: assert property (
    ((pending_request_reg & ~mask_reg) == '0) |-> !cpu_request_out)
    else $error("masked level raised the request");

  default_vec_a: assert property (
    (ack_state_reg == ACK_IDLE && ack_strobe && !svc_ok) |=>
      (!svc_valid_reg && svc_level_reg == `DEFAULT_LEVEL && isr_reg == $past(isr_reg)))
    else $error("withdrawn request did not give the default");

  smm_sticky_a: assert property (
    (smm_reg && !(cmd_valid && cmd_op == CMD_SMM_CLR)) |=> smm_reg)
    else $error("special mask mode dropped without command");

  rotated_c: cover property (cmd_valid && cmd_op == CMD_ROT_NONSPEC && isr_found);
  auto_rot_c: cover property (auto_eoi_fire && rot_auto_end_of_service_reg);
  smm_lower_c: cover property (smm_reg && isr_found && cpu_request_out && cand_rank > isr_rank);

endmodule

// ### hw/irq_priority_resolve.sv
// circular priority resolver: first set bit after the lowest level
`timescale 1ns/1ps
module irq_priority_resolve #(
  parameter int N  = 8,
  parameter int LW = 3
) (
  input  logic [N-1:0]  bits,
  input  logic [LW-1:0] lowest,
  output logic          found,
  output logic [LW-1:0] level,
  output logic [LW-1:0] rank
);
  always_comb begin
    logic [LW-1:0] idx;
    idx   = '0;
    found = 1'b0;
    level = '0;
    rank  = '0;
    // walk from lowest rank upward so the highest priority wins last
    for (int i = N - 1; i >= 0; i--) begin
      idx = LW'(32'(lowest) + 1 + i);
      if (bits[idx]) begin
        found = 1'b1;
        level = idx;
        rank  = LW'(i);
      end
    end
  end
endmodule

// ### hw/irq_trigger_detect.sv
// active-low request sensing, edge or level, into the pending bits
`timescale 1ns/1ps
module irq_trigger_detect #(
  parameter int N = 8
) (
  input  logic         clk,
  input  logic         nrst,
  input  logic [N-1:0] req_n,
  input  logic         level_mode,
  input  logic [N-1:0] clr_bits,
  output logic [N-1:0] pending
);
  logic [N-1:0] prev_reg;
  logic [N-1:0] prev_next;
  logic [N-1:0] pend_reg;
  logic [N-1:0] pend_next;
  logic [N-1:0] fall;

  always_comb begin
    prev_next = req_n;
    fall      = prev_reg & ~req_n;
    if (level_mode) begin
      pend_next = ~req_n;
    end else begin
      // a fresh edge beats an acknowledge clear in the same cycle
      pend_next = (pend_reg & ~clr_bits) | fall;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_reg <= '1;
      pend_reg <= '0;
    end else begin
      prev_reg <= prev_next;
      pend_reg <= pend_next;
    end
  end

  assign pending = pend_reg;
endmodule

// ### pkg/irq_defines.svh
// constants for the interrupt priority, mask and trigger bank
// Function
// - default nested order, level 0 highest, 7 lowest
// - acknowledge picks top unmasked pending, sets in-service
// - in-service held until end-of-service or auto clear
// - in-service blocks equal and lower priority requests
// - rotate nonspecific clears top, makes it lowest
// - priority is circular, next level becomes highest
// - rotate-auto mode clears and rotates after second ack
// - rotate-auto mode entered and left by commands
// - set-priority names lowest level, in-service untouched
// - rotate specific clears named bit and makes lowest
// - plain nonspecific clear leaves order unchanged
// - eight-bit mask, bit n disables level n only
// - mask gates pending output only, pending still latches; code leaves pending_out unmasked, gates request output and ack choice
// - withdrawn masked request yields default level 7 vector
// - special mask allows all unmasked except in-service
// - special mask stays until disabled by command
// - bank holds its own edge or level setting
// - active low inputs, edge mode latches falling edges
// - level mode recognises any low input
// - input must be low at first ack, else default
// - request output high for any allowed unmasked pending
// - nonspecific end-of-service clears top in-service bit
// - specific end-of-service clears exactly the named bit
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

`define LOWEST_RESET     3'h7
`define DEFAULT_LEVEL    3'h7
`define MASK_RESET       8'h00
`define ACK1_DATA        8'h00
`define VEC_BASE_DEFAULT 8'h20
`define VEC_LEVEL_BITS   3

`endif

// ### pkg/irq_pkg.sv
// types shared by the interrupt priority bank
package irq_pkg;

  typedef enum logic [3:0] {
    CMD_EOI_NONSPEC,
    CMD_EOI_SPEC,
    CMD_ROT_NONSPEC,
    CMD_ROT_SPEC,
    CMD_SET_PRIO,
    CMD_AUTO_END_OF_SERVICE_SET,
    CMD_AUTO_END_OF_SERVICE_CLR,
    CMD_ROT_AUTO_END_OF_SERVICE_SET,
    CMD_ROT_AUTO_END_OF_SERVICE_CLR,
    CMD_SMM_SET,
    CMD_SMM_CLR,
    CMD_EDGE_MODE,
    CMD_LEVEL_MODE
  } cmd_op_t;

  typedef enum {
    ACK_IDLE,
    ACK_WAIT
  } ack_state_t;

endpackage

// ### test/host_model.sv
// host core model: acknowledge cycles, commands and mask writes
`timescale 1ns/1ps
module host_model import irq_pkg::*; (
  input  logic       clk,
  input  logic [7:0] data_out,
  input  logic       data_oe,
  output logic       ack_strobe,
  output logic       cmd_valid,
  output cmd_op_t    cmd_op,
  output logic [2:0] cmd_level,
  output logic       mask_wr,
  output logic [7:0] mask_wdata
);
  initial begin
    ack_strobe = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = cmd_op.first();
    cmd_level = 3'h0;
    mask_wr = 1'b0;
    mask_wdata = 8'h00;
  end
  // one acknowledge cycle; data is taken while data_oe stands
  task automatic ack(output logic [7:0] d, output logic oe);
    @(negedge clk);
    ack_strobe = 1'b1;
    @(negedge clk);
    ack_strobe = 1'b0;
    d = data_out;
    oe = data_oe;
  endtask
  // mode set and clear travel as commands
  task automatic cmd(input cmd_op_t op, input logic [2:0] lvl);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_level = lvl;
    @(negedge clk);
    cmd_valid = 1'b0;
    // level field is meaningless outside a command, so it is scrambled
    cmd_level = ~lvl;
  endtask
  task automatic mask(input logic [7:0] m);
    @(negedge clk);
    mask_wr = 1'b1;
    mask_wdata = m;
    @(negedge clk);
    mask_wr = 1'b0;
    mask_wdata = ~m;
  endtask
endmodule

// ### test/test_irq_priority_mask_trigger.sv
// self-checking bench for the priority, mask and trigger bank
`timescale 1ns/1ps
module test_irq_priority_mask_trigger import irq_pkg::*;;
  logic clk, nrst, ack_strobe, cmd_valid, mask_wr, cpu_request_out, data_oe;
  logic [7:0] req_n, mask_wdata, data_out, level_mask_out, pending_out, in_service_out;
  logic [2:0] cmd_level, lowest_out;
  cmd_op_t cmd_op;
  int mismatches = 0;
  int n_checks = 0;

  irq_priority_mask_trigger dut (.clk(clk), .nrst(nrst), .req_n(req_n), .ack_strobe(ack_strobe),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_level(cmd_level), .mask_wr(mask_wr),
    .mask_wdata(mask_wdata), .cpu_request_out(cpu_request_out), .data_out(data_out),
    .data_oe(data_oe), .level_mask_out(level_mask_out), .pending_out(pending_out),
    .in_service_out(in_service_out), .lowest_out(lowest_out));
  host_model host (.clk(clk), .data_out(data_out), .data_oe(data_oe), .ack_strobe(ack_strobe),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_level(cmd_level), .mask_wr(mask_wr),
    .mask_wdata(mask_wdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic req(input logic [7:0] v);
    @(negedge clk);
    req_n = v;
    cyc(2);
  endtask
  // two acknowledge cycles: 00h first, then the vector
  task automatic ack_pair(input logic [7:0] vec);
    logic [7:0] d;
    logic oe;
    host.ack(d, oe);
    chk("first ack data", 8'h00, d);
    chk("first ack enable", 8'h01, {7'h0, oe});
    host.ack(d, oe);
    chk("vector", vec, d);
    chk("second ack enable", 8'h01, {7'h0, oe});
  endtask
  task automatic state(input logic [7:0] in_service_reg, input logic [2:0] low, input logic cpu);
    chk("in service", in_service_reg, in_service_out);
    chk("lowest", {5'h0, low}, {5'h0, lowest_out});
    chk("cpu request", {7'h0, cpu}, {7'h0, cpu_request_out});
  endtask

  task automatic t_reset;
    state(8'h00, 3'h7, 1'b0);
    chk("pending", 8'h00, pending_out);
    chk("mask", 8'h00, level_mask_out);
  endtask
  task automatic t_nested;
    req(8'hd7);
    chk("pending", 8'h28, pending_out);
    state(8'h00, 3'h7, 1'b1);
    ack_pair(8'h23);
    state(8'h08, 3'h7, 1'b0);
    req(8'hd5);
    state(8'h08, 3'h7, 1'b1);
    ack_pair(8'h21);
    host.cmd(CMD_EOI_NONSPEC, 3'h0);
    state(8'h08, 3'h7, 1'b0);
    host.cmd(CMD_EOI_SPEC, 3'h3);
    state(8'h00, 3'h7, 1'b1);
    req(8'hff);
  endtask
  task automatic t_rotate;
    // level 5 is still pending from the last scenario; its line must be low at the first ack
    req(8'hdf);
    ack_pair(8'h25);
    host.cmd(CMD_ROT_NONSPEC, 3'h0);
    state(8'h00, 3'h5, 1'b0);
    req(8'haf);
    ack_pair(8'h26);
    host.cmd(CMD_ROT_SPEC, 3'h6);
    state(8'h00, 3'h6, 1'b1);
    ack_pair(8'h24);
    host.cmd(CMD_SET_PRIO, 3'h2);
    state(8'h10, 3'h2, 1'b0);
    host.cmd(CMD_EOI_SPEC, 3'h4);
    host.cmd(CMD_SET_PRIO, 3'h7);
    req(8'hff);
  endtask
  task automatic t_mask;
    host.mask(8'h04);
    req(8'hfb);
    chk("pending", 8'h04, pending_out);
    state(8'h00, 3'h7, 1'b0);
    host.mask(8'h00);
    state(8'h00, 3'h7, 1'b1);
    host.mask(8'h04);
    req(8'hff);
    host.mask(8'h00);
    ack_pair(8'h27);
    // a default vector leaves the stale pending bit in place, so the request stays up
    state(8'h00, 3'h7, 1'b1);
    req(8'hfb);
    ack_pair(8'h22);
    state(8'h04, 3'h7, 1'b0);
    host.cmd(CMD_EOI_NONSPEC, 3'h0);
    req(8'hff);
  endtask
  task automatic t_special;
    req(8'hfe);
    ack_pair(8'h20);
    host.mask(8'h01);
    host.cmd(CMD_SMM_SET, 3'h0);
    req(8'hbe);
    state(8'h01, 3'h7, 1'b1);
    ack_pair(8'h26);
    host.cmd(CMD_EOI_SPEC, 3'h6);
    req(8'hde);
    state(8'h01, 3'h7, 1'b1);
    host.cmd(CMD_SMM_CLR, 3'h0);
    state(8'h01, 3'h7, 1'b0);
    host.cmd(CMD_EOI_SPEC, 3'h0);
    host.mask(8'h00);
    ack_pair(8'h25);
    host.cmd(CMD_EOI_SPEC, 3'h5);
    req(8'hff);
  endtask
  task automatic t_trigger;
    host.cmd(CMD_LEVEL_MODE, 3'h0);
    req(8'hf7);
    chk("pending", 8'h08, pending_out);
    ack_pair(8'h23);
    // level request is withdrawn before the end of service
    req(8'hff);
    host.cmd(CMD_EOI_NONSPEC, 3'h0);
    cyc(1);
    chk("pending", 8'h00, pending_out);
    state(8'h00, 3'h7, 1'b0);
    host.cmd(CMD_EDGE_MODE, 3'h0);
    req(8'hf7);
    ack_pair(8'h23);
    host.cmd(CMD_EOI_NONSPEC, 3'h0);
    cyc(2);
    chk("pending", 8'h00, pending_out);
    req(8'hff);
  endtask
  task automatic t_auto;
    host.cmd(CMD_AUTO_END_OF_SERVICE_SET, 3'h0);
    req(8'hfb);
    ack_pair(8'h22);
    state(8'h00, 3'h7, 1'b0);
    host.cmd(CMD_AUTO_END_OF_SERVICE_CLR, 3'h0);
    host.cmd(CMD_ROT_AUTO_END_OF_SERVICE_SET, 3'h0);
    req(8'hff);
    req(8'hfb);
    ack_pair(8'h22);
    state(8'h00, 3'h2, 1'b0);
    host.cmd(CMD_ROT_AUTO_END_OF_SERVICE_CLR, 3'h0);
    req(8'hf7);
    ack_pair(8'h23);
    state(8'h08, 3'h2, 1'b0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #20000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    nrst = 1'b0;
    req_n = 8'hff;
    cyc(4);
    nrst = 1'b1;
    cyc(1);
    t_reset;
    t_nested;
    t_rotate;
    t_mask;
    t_special;
    t_trigger;
    t_auto;
    tally_and_finish;
  end
endmodule
